// ### core/mri_pkg.sv
// Constants and types for the read-input-registers request handler.
// Assumes request bytes arrive already de-framed, one binary byte per beat.
package mri_pkg;

  // ----------------------------------------------------------------
  // Request layout
  // ----------------------------------------------------------------
  localparam logic [2:0]  REQ_BYTES            = 3'h7;
  localparam logic [2:0]  POS_ADDR             = 3'h0;
  localparam logic [2:0]  POS_REQUEST_FUNCTION_CODE             = 3'h1;
  localparam logic [2:0]  POS_START_HI         = 3'h2;
  localparam logic [2:0]  POS_START_LO         = 3'h3;
  localparam logic [2:0]  POS_COUNT_HI         = 3'h4;
  localparam logic [2:0]  POS_COUNT_LO         = 3'h5;
  localparam logic [7:0]  REQUEST_FUNCTION_CODE_READ_INPUT_REGS = 8'h04;

  // ----------------------------------------------------------------
  // Start register fields and limits
  // ----------------------------------------------------------------
  localparam int          OFFSET_MSB           = 15;
  localparam int          OFFSET_LSB           = 9;
  localparam int          WORD_MSB             = 8;
  localparam int          WORD_LSB             = 0;
  localparam logic [15:0] COUNT_MIN            = 16'h0001;
  localparam logic [15:0] COUNT_MAX            = 16'h007D;
  localparam logic [9:0]  WORDS_PER_BLOCK      = 10'h200;
  localparam logic [6:0]  NUM_BLOCKS           = 7'h04;
  localparam int          BLOCK_SEL_W          = 2;
  localparam int          MEM_ADDR_W           = 11;
  localparam logic [9:0]  BYTES_PER_WORD       = 10'h002;
  localparam logic [15:0] BASE_BLOCK_DEFAULT   = 16'h0384;

  // ----------------------------------------------------------------
  // Reply buffer
  // ----------------------------------------------------------------
  localparam int          FIFO_WIDTH           = 9;
  localparam int          FIFO_DEPTH           = 32;

  // ----------------------------------------------------------------
  // Error codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  ERR_NONE             = 2'h0;
  localparam logic [1:0]  ERR_COUNT            = 2'h1;
  localparam logic [1:0]  ERR_RANGE            = 2'h2;
  localparam logic [7:0]  BYTE_RST             = 8'h00;
  localparam logic [15:0] WORD_RST             = 16'h0000;

  typedef enum logic [2:0] {
    MRI_RECV,
    MRI_CHECK,
    MRI_HDR,
    MRI_READ,
    MRI_HI,
    MRI_LO,
    MRI_LRC
  } mri_state_t;

endpackage

// ### core/mri_stream_if.sv
// Valid/ready byte stream between the handler and its reply buffer.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface mri_stream_if #(
  parameter int W = 9
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### core/mri_fifo.sv
// Reply buffer with a registered output stage.
// Assumes one clock; drain side may stall at any time.
`timescale 1ns/100ps
module mri_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic   clock_i,
  input  wire logic   reset_n_i,
  mri_stream_if.snk   in_s,
  mri_stream_if.src   out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    push           = in_s.valid && in_s.ready;
    pop            = (count_reg != '0) && (!out_valid_reg || out_s.ready);
    wr_ptr_next    = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next    = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next     = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Clear on drain so the last flag never outlives valid
    out_data_next  = pop ? store[rd_ptr_reg] : (out_s.ready ? '0 : out_data_reg);
    out_valid_next = pop ? 1'b1 : (out_s.ready ? 1'b0 : out_valid_reg);
  end

  assign in_s.ready  = (count_reg != DEPTH_CNT);
  assign out_s.valid = out_valid_reg;
  assign out_s.data  = out_data_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg  <= out_data_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      store[wr_ptr_reg] <= in_s.data;
    end
  end
endmodule

// ### core/mri_mem.sv
// Word store for the configured data blocks, one write and one read port.
// Assumes loads and reads come from logic on the same clock.
`timescale 1ns/100ps
module mri_mem
  import mri_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  wr_en_i,
  input  wire logic [MEM_ADDR_W-1:0] wr_addr_i,
  input  wire logic [15:0]           wr_data_i,
  input  wire logic                  rd_en_i,
  input  wire logic [MEM_ADDR_W-1:0] rd_addr_i,
  output logic      [15:0]           rd_data_o
);
  logic [15:0] words [2**MEM_ADDR_W];
  logic [15:0] rd_data_reg, rd_data_next;

  always_comb begin
    rd_data_next = rd_en_i ? words[rd_addr_i] : rd_data_reg;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_reg <= WORD_RST;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      words[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = rd_data_reg;
endmodule

// ### core/mri_handler.sv
// Read-input-registers request handler: decodes, checks, reads, replies.
// Assumes de-framed request bytes with a last flag, all on clock_i.
`timescale 1ns/100ps
module mri_handler
  import mri_pkg::*;
#(
  parameter logic [15:0] BASE_BLOCK = BASE_BLOCK_DEFAULT
) (
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  input  wire logic [7:0]            station_addr_i,
  input  wire logic                  rx_valid_i,
  input  wire logic [7:0]            rx_data_i,
  input  wire logic                  rx_last_i,
  output logic                       rx_ready_o,
  output logic                       tx_valid_o,
  output logic      [7:0]            tx_data_o,
  output logic                       tx_last_o,
  input  wire logic                  tx_ready_i,
  input  wire logic                  mem_wr_en_i,
  input  wire logic [MEM_ADDR_W-1:0] mem_wr_addr_i,
  input  wire logic [15:0]           mem_wr_data_i,
  output logic                       error_o,
  output logic      [1:0]            error_code_o,
  output logic      [15:0]           memory_block_number_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mri_state_t             state_reg, state_next;
  logic [2:0]             byte_cnt_reg, byte_cnt_next;
  logic                   over_reg, over_next;
  logic [7:0]             addr_reg, addr_next;
  logic [7:0]             request_function_code_reg, request_function_code_next;
  logic [15:0]            start_reg, start_next;
  logic [15:0]            count_reg, count_next;
  logic [7:0]             rx_sum_reg, rx_sum_next;
  logic                   rx_ready_reg, rx_ready_next;
  logic [1:0]             hdr_idx_reg, hdr_idx_next;
  logic [6:0]             words_left_reg, words_left_next;
  logic [9:0]             byte_idx_reg, byte_idx_next;
  logic [BLOCK_SEL_W-1:0] blk_sel_reg, blk_sel_next;
  logic [7:0]             tx_sum_reg, tx_sum_next;
  logic                   error_reg, error_next;
  logic [1:0]             error_code_reg, error_code_next;
  logic [15:0]            memory_block_number_reg, memory_block_number_next;

  // ----------------------------------------------------------------
  // Decode of the stored request
  // ----------------------------------------------------------------
  logic [6:0]             block_offset_field;
  logic [8:0]             block_word_index;
  logic [9:0]             read_end;
  logic                   rx_take;
  logic                   tx_take;
  logic [7:0]             push_byte;
  logic                   push_last;
  logic                   push_valid;
  logic [15:0]            rd_word;
  logic                   mem_rd_en;
  logic [MEM_ADDR_W-1:0]  mem_rd_addr;

  mri_stream_if #(.W(FIFO_WIDTH)) push_if ();
  mri_stream_if #(.W(FIFO_WIDTH)) pop_if ();

  assign block_offset_field = start_reg[OFFSET_MSB:OFFSET_LSB];
  assign block_word_index   = start_reg[WORD_MSB:WORD_LSB];
  assign read_end           = {1'b0, block_word_index} + {3'h0, count_reg[6:0]};
  assign rx_take            = rx_valid_i && rx_ready_reg;
  assign tx_take            = push_valid && push_if.ready;
  assign mem_rd_en          = (state_reg == MRI_READ);
  assign mem_rd_addr        = {blk_sel_reg, byte_idx_reg[9:1]};

  // ----------------------------------------------------------------
  // Reply byte selection
  // ----------------------------------------------------------------
  always_comb begin
    push_byte  = BYTE_RST;
    push_last  = 1'b0;
    push_valid = 1'b0;
    unique case (state_reg)
      MRI_HDR: begin
        push_valid = 1'b1;
        unique case (hdr_idx_reg)
          2'h0:    push_byte = addr_reg;
          2'h1:    push_byte = request_function_code_reg;
          default: push_byte = {count_reg[6:0], 1'b0};
        endcase
      end
      MRI_HI: begin
        push_valid = 1'b1;
        push_byte  = rd_word[15:8];
      end
      MRI_LO: begin
        push_valid = 1'b1;
        push_byte  = rd_word[7:0];
      end
      MRI_LRC: begin
        push_valid = 1'b1;
        push_byte  = 8'h00 - tx_sum_reg;
        push_last  = 1'b1;
      end
      MRI_RECV, MRI_CHECK, MRI_READ: begin
        push_valid = 1'b0;
      end
    endcase
  end

  assign push_if.valid = push_valid;
  assign push_if.data  = {push_last, push_byte};
  assign pop_if.ready  = tx_ready_i;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next                 = state_reg;
    byte_cnt_next              = byte_cnt_reg;
    over_next                  = over_reg;
    addr_next                  = addr_reg;
    request_function_code_next = request_function_code_reg;
    start_next                 = start_reg;
    count_next                 = count_reg;
    rx_sum_next                = rx_sum_reg;
    rx_ready_next              = rx_ready_reg;
    hdr_idx_next               = hdr_idx_reg;
    words_left_next            = words_left_reg;
    byte_idx_next              = byte_idx_reg;
    blk_sel_next               = blk_sel_reg;
    tx_sum_next                = tx_sum_reg;
    error_next                 = 1'b0;
    error_code_next            = error_code_reg;
    memory_block_number_next   = memory_block_number_reg;
    unique case (state_reg)
      MRI_RECV: begin
        if (rx_take) begin
          rx_sum_next = rx_sum_reg + rx_data_i;
          unique case (byte_cnt_reg)
            POS_ADDR:     addr_next = rx_data_i;
            POS_REQUEST_FUNCTION_CODE:     request_function_code_next = rx_data_i;
            POS_START_HI: start_next = {rx_data_i, start_reg[7:0]};
            POS_START_LO: start_next = {start_reg[15:8], rx_data_i};
            POS_COUNT_HI: count_next = {rx_data_i, count_reg[7:0]};
            POS_COUNT_LO: count_next = {count_reg[15:8], rx_data_i};
            default:      ;
          endcase
          if (byte_cnt_reg == REQ_BYTES) begin
            over_next = 1'b1;
          end else begin
            byte_cnt_next = byte_cnt_reg + 3'h1;
          end
          if (rx_last_i) begin
            rx_ready_next = 1'b0;
            state_next    = MRI_CHECK;
          end
        end
      end
      MRI_CHECK: begin
        byte_cnt_next = 3'h0;
        over_next     = 1'b0;
        rx_sum_next   = BYTE_RST;
        rx_ready_next = 1'b1;
        state_next    = MRI_RECV;
        if (over_reg || (byte_cnt_reg != REQ_BYTES) || (rx_sum_reg != BYTE_RST) ||
            (addr_reg != station_addr_i) ||
            (request_function_code_reg != REQUEST_FUNCTION_CODE_READ_INPUT_REGS)) begin
          state_next = MRI_RECV;
        end else if ((count_reg < COUNT_MIN) || (count_reg > COUNT_MAX)) begin
          error_next      = 1'b1;
          error_code_next = ERR_COUNT;
        end else if ((block_offset_field >= NUM_BLOCKS) ||
                     (read_end > WORDS_PER_BLOCK)) begin
          error_next      = 1'b1;
          error_code_next = ERR_RANGE;
        end else begin
          rx_ready_next            = 1'b0;
          error_code_next          = ERR_NONE;
          memory_block_number_next = BASE_BLOCK + {9'h000, block_offset_field};
          blk_sel_next             = block_offset_field[BLOCK_SEL_W-1:0];
          byte_idx_next            = {block_word_index, 1'b0};
          words_left_next          = count_reg[6:0];
          hdr_idx_next             = 2'h0;
          tx_sum_next              = BYTE_RST;
          state_next               = MRI_HDR;
        end
      end
      MRI_HDR: begin
        if (tx_take) begin
          tx_sum_next  = tx_sum_reg + push_byte;
          hdr_idx_next = hdr_idx_reg + 2'h1;
          if (hdr_idx_reg == 2'h2) begin
            state_next = MRI_READ;
          end
        end
      end
      MRI_READ: begin
        state_next = MRI_HI;
      end
      MRI_HI: begin
        if (tx_take) begin
          tx_sum_next = tx_sum_reg + push_byte;
          state_next  = MRI_LO;
        end
      end
      MRI_LO: begin
        if (tx_take) begin
          tx_sum_next     = tx_sum_reg + push_byte;
          byte_idx_next   = byte_idx_reg + BYTES_PER_WORD;
          words_left_next = words_left_reg - 7'h01;
          state_next      = (words_left_reg == 7'h01) ? MRI_LRC : MRI_READ;
        end
      end
      MRI_LRC: begin
        if (tx_take) begin
          rx_ready_next = 1'b1;
          state_next    = MRI_RECV;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg                 <= MRI_RECV;
      byte_cnt_reg              <= 3'h0;
      over_reg                  <= 1'b0;
      addr_reg                  <= BYTE_RST;
      request_function_code_reg <= BYTE_RST;
      start_reg                 <= WORD_RST;
      count_reg                 <= WORD_RST;
      rx_sum_reg                <= BYTE_RST;
      rx_ready_reg              <= 1'b1;
      hdr_idx_reg               <= 2'h0;
      words_left_reg            <= 7'h00;
      byte_idx_reg              <= 10'h000;
      blk_sel_reg               <= '0;
      tx_sum_reg                <= BYTE_RST;
      error_reg                 <= 1'b0;
      error_code_reg            <= ERR_NONE;
      memory_block_number_reg   <= WORD_RST;
    end else begin
      state_reg                 <= state_next;
      byte_cnt_reg              <= byte_cnt_next;
      over_reg                  <= over_next;
      addr_reg                  <= addr_next;
      request_function_code_reg <= request_function_code_next;
      start_reg                 <= start_next;
      count_reg                 <= count_next;
      rx_sum_reg                <= rx_sum_next;
      rx_ready_reg              <= rx_ready_next;
      hdr_idx_reg               <= hdr_idx_next;
      words_left_reg            <= words_left_next;
      byte_idx_reg              <= byte_idx_next;
      blk_sel_reg               <= blk_sel_next;
      tx_sum_reg                <= tx_sum_next;
      error_reg                 <= error_next;
      error_code_reg            <= error_code_next;
      memory_block_number_reg   <= memory_block_number_next;
    end
  end

  // ----------------------------------------------------------------
  // Block store and reply buffer
  // ----------------------------------------------------------------
  mri_mem u_mem (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (mem_wr_en_i),
    .wr_addr_i (mem_wr_addr_i),
    .wr_data_i (mem_wr_data_i),
    .rd_en_i   (mem_rd_en),
    .rd_addr_i (mem_rd_addr),
    .rd_data_o (rd_word)
  );

  mri_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .in_s      (push_if),
    .out_s     (pop_if)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rx_ready_o            = rx_ready_reg;
  assign tx_valid_o            = pop_if.valid;
  assign tx_data_o             = pop_if.data[7:0];
  assign tx_last_o             = pop_if.data[8];
  assign error_o               = error_reg;
  assign error_code_o          = error_code_reg;
  assign memory_block_number_o = memory_block_number_reg;
endmodule

// ### tb/mri_chk.sv
// Concurrent checks on the request handler's ports.
// Assumes it is bound to every mri_handler instance.
`timescale 1ns/100ps
module mri_chk
  import mri_pkg::*;
#(
  parameter logic [15:0] BASE_BLOCK = BASE_BLOCK_DEFAULT
) (
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        rx_valid_i,
  input wire logic        rx_last_i,
  input wire logic        rx_ready_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_last_o,
  input wire logic        tx_ready_i,
  input wire logic        error_o,
  input wire logic [1:0]  error_code_o,
  input wire logic [15:0] memory_block_number_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  wire logic last_in = rx_valid_i && rx_ready_o && rx_last_i;

  a_ready_drop: assert property (last_in |=> !rx_ready_o)
    else $error("ready stayed high after last byte");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("reply byte changed while stalled");
  a_last_valid: assert property (tx_last_o |-> tx_valid_o)
    else $error("last flag without valid");
  a_last_once: assert property (tx_last_o && tx_ready_i |=> !tx_last_o)
    else $error("two last bytes in a row");
  a_err_pulse: assert property (error_o |=> !error_o)
    else $error("error pulse too long");
  a_err_code: assert property (error_o |->
    error_code_o == ERR_COUNT || error_code_o == ERR_RANGE)
    else $error("error without code");
  a_err_ready: assert property (error_o |-> rx_ready_o && !$past(rx_ready_o))
    else $error("error pulse off the check cycle");
  a_code_cause: assert property ($changed(error_code_o) && error_code_o != ERR_NONE
    |-> error_o || $past(error_o))
    else $error("error code set without pulse");
  a_blk_base: assert property ($changed(memory_block_number_o) |->
    16'(memory_block_number_o - BASE_BLOCK) < 16'h0004)
    else $error("block number off base");

  c_reply: cover property (tx_last_o && tx_ready_i);
  c_range: cover property (error_o && error_code_o == ERR_RANGE);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule

bind mri_handler mri_chk #(.BASE_BLOCK(BASE_BLOCK)) u_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .rx_valid_i(rx_valid_i),
  .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
  .error_o(error_o), .error_code_o(error_code_o),
  .memory_block_number_o(memory_block_number_o));

// ### tb/mri_master_model.sv
// Remote master: sends request frames, drains replies slowly.
// Assumes one clock shared with the handler.
`timescale 1ns/100ps
module mri_master_model (
  input  wire logic       clock_i,
  input  wire logic       hold_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_last_o,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o
);
  logic [8:0] got_q [$];
  logic [1:0] phase;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_last_o = 1'b0;
    tx_ready_o = 1'b0;
    phase = 2'h0;
  end
  // Drain three beats in four unless held
  always @(posedge clock_i) begin
    if (tx_valid_i && tx_ready_o) got_q.push_back({tx_last_i, tx_data_i});
    phase <= phase + 2'h1;
    tx_ready_o <= !hold_i && phase != 2'h3;
  end
  // Start register from block offset and byte index
  function automatic logic [15:0] start_of(input logic [6:0] off, input logic [9:0] y);
    return {off, y[9:1]};
  endfunction
  // Address, function, start, count, then LRC
  task automatic send(input logic [7:0] b [6], input logic [7:0] flip = 8'h00);
    logic [7:0] s;
    logic [7:0] d;
    s = 8'h00;
    for (int i = 0; i < 7; i++) begin
      d = (i < 6) ? b[i] : (8'h00 - s) ^ flip;
      s = s + d;
      rx_valid_o <= 1'b1;
      rx_data_o <= d;
      rx_last_o <= (i == 6);
      @(posedge clock_i);
      while (!rx_ready_i) @(posedge clock_i);
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
    rx_last_o <= 1'b0;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the request handler.
// Assumes the master model and the checker are compiled alongside.
`timescale 1ns/100ps
module testbench
  import mri_pkg::*;
;
  localparam logic [15:0] BASE = 16'h0384;
  logic        clock_i;
  logic        reset_n_i;
  logic [7:0]  station;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_last;
  logic        rx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic        tx_ready;
  logic        wr_en;
  logic [10:0] wr_addr;
  logic [15:0] wr_data;
  logic        err;
  logic [1:0]  err_code;
  logic [15:0] blk;
  logic        hold;
  int          num_errors;
  int          n_checks;
  int          n_err;

  mri_handler #(.BASE_BLOCK(BASE)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .station_addr_i(station), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_last_i(rx_last), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_ready_i(tx_ready),
    .mem_wr_en_i(wr_en), .mem_wr_addr_i(wr_addr), .mem_wr_data_i(wr_data),
    .error_o(err), .error_code_o(err_code), .memory_block_number_o(blk));
  mri_master_model m (.clock_i(clock_i), .hold_i(hold), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_last_o(rx_last), .rx_ready_i(rx_ready),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_ready_o(tx_ready));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (err === 1'b1) n_err <= n_err + 1;

  function automatic logic [15:0] pat(input logic [10:0] a);
    return {a[7:0], 5'h00, a[10:8]} ^ 16'hA1A2;
  endfunction
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One request; ex 3 means silently dropped
  task automatic do_req(input logic [7:0] ad, input logic [7:0] fn,
                        input logic [15:0] st, input logic [15:0] cnt, input logic [1:0] ex,
                        input logic [7:0] flip = 8'h00);
    logic [7:0]  e [$];
    logic [7:0]  s;
    logic [15:0] w;
    int          t;
    int          e0;
    m.got_q.delete();
    e0 = n_err;
    m.send('{ad, fn, st[15:8], st[7:0], cnt[15:8], cnt[7:0]}, flip);
    if (ex == ERR_NONE) begin
      e = {ad, fn, 8'(2 * cnt)};
      for (int i = 0; i < cnt; i++) begin
        w = pat({st[10:9], st[8:0] + i[8:0]});
        e.push_back(w[15:8]);
        e.push_back(w[7:0]);
      end
      s = 8'h00;
      foreach (e[i]) s = s + e[i];
      e.push_back(8'h00 - s);
      t = 0;
      while (m.got_q.size() < e.size() && t < 4000) begin
        @(posedge clock_i);
        t++;
      end
      chk("reply_length", 16'(e.size()), 16'(m.got_q.size()));
      for (int i = 0; i < e.size() && i < m.got_q.size(); i++)
        chk("reply_byte", {7'h00, i == e.size() - 1, e[i]}, {7'h00, m.got_q[i]});
      chk("block_number", BASE + st[15:9], blk);
    end else begin
      repeat (30) @(posedge clock_i);
      chk("error_pulses", (ex == 2'h3) ? 16'h0000 : 16'h0001, 16'(n_err - e0));
      if (ex != 2'h3) chk("error_code", {14'h0000, ex}, {14'h0000, err_code});
      chk("no_reply", 16'h0000, 16'(m.got_q.size()));
    end
  endtask

  task automatic t_example();
    do_req(8'h05, REQUEST_FUNCTION_CODE_READ_INPUT_REGS, m.start_of(7'h01, 10'h180), 16'h0003,
           ERR_NONE);
    $display("t_example done");
  endtask
  task automatic t_count();
    do_req(8'h05, 8'h04, 16'h0000, 16'h0000, ERR_COUNT);
    do_req(8'h05, 8'h04, 16'h0000, 16'h007E, ERR_COUNT);
    do_req(8'h05, 8'h04, 16'h0000, 16'h0101, ERR_COUNT);
    do_req(8'h05, 8'h04, 16'h0600, 16'h0001, ERR_NONE);
    hold <= 1'b1;
    fork
      begin
        repeat (200) @(posedge clock_i);
        hold <= 1'b0;
      end
    join_none
    do_req(8'h05, 8'h04, 16'h0000, 16'h007D, ERR_NONE);
    $display("t_count done");
  endtask
  task automatic t_range();
    do_req(8'h05, 8'h04, m.start_of(7'h04, 10'h000), 16'h0001, ERR_RANGE);
    do_req(8'h05, 8'h04, m.start_of(7'h7F, 10'h000), 16'h0001, ERR_RANGE);
    do_req(8'h05, 8'h04, m.start_of(7'h02, 10'h3FE), 16'h0002, ERR_RANGE);
    do_req(8'h05, 8'h04, m.start_of(7'h02, 10'h3FC), 16'h0002, ERR_NONE);
    do_req(8'h05, 8'h04, m.start_of(7'h03, 10'h3FE), 16'h0001, ERR_NONE);
    $display("t_range done");
  endtask
  task automatic t_drop();
    do_req(8'h06, 8'h04, 16'h0000, 16'h0001, 2'h3);
    do_req(8'h05, 8'h03, 16'h0000, 16'h0001, 2'h3);
    do_req(8'h05, 8'h04, 16'h0000, 16'h0001, 2'h3, 8'h01);
    station <= 8'h11;
    @(posedge clock_i);
    do_req(8'h11, 8'h04, 16'h0200, 16'h0002, ERR_NONE);
    $display("t_drop done");
  endtask

  initial begin
    reset_n_i = 1'b0;
    station = 8'h05;
    wr_en = 1'b0;
    wr_addr = 11'h000;
    wr_data = 16'h0000;
    hold = 1'b0;
    repeat (4) @(posedge clock_i);
    chk("reset_ready", 16'h0001, {15'h0000, rx_ready});
    chk("reset_valid", 16'h0000, {15'h0000, tx_valid});
    chk("reset_block", 16'h0000, blk);
    chk("reset_error", 16'h0000, {12'h000, err, err_code, tx_last});
    reset_n_i <= 1'b1;
    for (int a = 0; a < 2048; a++) begin
      @(posedge clock_i);
      wr_en <= 1'b1;
      wr_addr <= a[10:0];
      wr_data <= pat(a[10:0]);
    end
    @(posedge clock_i);
    wr_en <= 1'b0;
    @(posedge clock_i);
    t_example();
    t_count();
    t_range();
    t_drop();
    print_verdict();
  end
  initial begin
    #300000;
    num_errors++;
    print_verdict();
  end
endmodule
